// ==== sbst_defines.svh ====
// constants of the sram boundary scan test port: codes, field positions, lengths
// assumes inclusion by bare name from the package and the design files
`ifndef SBST_DEFINES_SVH
`define SBST_DEFINES_SVH

// instruction register
`define SBST_IR_W        3
`define SBST_IR_EXTEST   3'h0
`define SBST_IR_IDCODE   3'h1
`define SBST_IR_SAMPLEZ  3'h2
`define SBST_IR_RSVD3    3'h3
`define SBST_IR_SAMPLE   3'h4
`define SBST_IR_RSVD5    3'h5
`define SBST_IR_RSVD6    3'h6
`define SBST_IR_BYPASS   3'h7
`define SBST_IR_CAP_VAL  3'h1
`define SBST_IR_RST_VAL  3'h1

// identification register layout
`define SBST_ID_W        32
`define SBST_ID_REV_MSB  31
`define SBST_ID_REV_LSB  29
`define SBST_ID_PART_MSB 28
`define SBST_ID_PART_LSB 12
`define SBST_ID_MFR_MSB  11
`define SBST_ID_MFR_LSB  1
`define SBST_ID_PRES_BIT 0
`define SBST_ID_PRES_VAL 1'b1

// boundary ring
`define SBST_BSR_LEN     109
`define SBST_PIN_CNT     108
`define SBST_OE_CELL     108
`define SBST_OE_CELL_RST 1'b0

// timing counts
`define SBST_TLR_TMS_CNT 5
`define SBST_SYNC_STAGES 3

`endif

// ==== sbst_pkg.sv ====
// types of the sram boundary scan test port
// assumes sbst_defines.svh is on the include path
package sbst_pkg;
  `include "sbst_defines.svh"

  typedef enum logic [`SBST_IR_W-1:0] {
    SBST_EXTEST  = `SBST_IR_EXTEST,
    SBST_IDCODE  = `SBST_IR_IDCODE,
    SBST_SAMPLEZ = `SBST_IR_SAMPLEZ,
    SBST_RSVD3   = `SBST_IR_RSVD3,
    SBST_SAMPLE  = `SBST_IR_SAMPLE,
    SBST_RSVD5   = `SBST_IR_RSVD5,
    SBST_RSVD6   = `SBST_IR_RSVD6,
    SBST_BYPASS  = `SBST_IR_BYPASS
  } sbst_instr_t;

  // gray steps along the capture/shift/update walk
  typedef enum logic [3:0] {
    SBST_TLR      = 4'h0,
    SBST_RTI      = 4'h1,
    SBST_SEL_DR   = 4'h3,
    SBST_CAP_DR   = 4'h2,
    SBST_SHIFT_DR = 4'h6,
    SBST_EX1_DR   = 4'h7,
    SBST_PAUSE_DR = 4'h5,
    SBST_EX2_DR   = 4'h4,
    SBST_UPD_DR   = 4'hc,
    SBST_SEL_IR   = 4'hd,
    SBST_CAP_IR   = 4'hf,
    SBST_SHIFT_IR = 4'he,
    SBST_EX1_IR   = 4'ha,
    SBST_PAUSE_IR = 4'hb,
    SBST_EX2_IR   = 4'h9,
    SBST_UPD_IR   = 4'h8
  } sbst_state_t;

  // control word handed from the test clock to the system clock
  typedef struct packed {
    sbst_instr_t                instr;
    logic [`SBST_BSR_LEN-1:0]   upd;
  } sbst_ctrl_t;
endpackage

// ==== sbst_xfer.sv ====
// word crossing between two clocks by toggle handshake
// assumes each side has a synchronous reset in its own domain
`timescale 1ns/1ps
module sbst_xfer #(
  parameter int         W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // source side
  input  wire logic         i_src_clk,
  input  wire logic         i_src_rst,
  input  wire logic [W-1:0] i_src_data,
  // destination side
  input  wire logic         i_dst_clk,
  input  wire logic         i_dst_rst,
  output logic      [W-1:0] o_dst_data,
  output logic              o_dst_tick
);
  logic [W-1:0] hold_r;
  logic         req_r;
  logic [2:0]   ack_s_r;
  logic         ack_seen_r;
  logic [2:0]   req_s_r;
  logic         req_seen_r;

  // source: refresh the held word only once the previous one was taken
  always_ff @(posedge i_src_clk) begin
    if (i_src_rst) begin
      ack_s_r    <= 3'h0;
      ack_seen_r <= 1'b0;
    end else begin
      ack_s_r <= {ack_s_r[1:0], req_seen_r};
      if (ack_s_r[1] == ack_s_r[2]) begin
        ack_seen_r <= ack_s_r[2];
      end
    end
  end

  always_ff @(posedge i_src_clk) begin
    if (i_src_rst) begin
      hold_r <= RST;
      req_r  <= 1'b0;
    end else if (req_r == ack_seen_r) begin
      hold_r <= i_src_data;
      req_r  <= ~req_r;
    end
  end

  // destination: hold_r is stable while the request is outstanding
  always_ff @(posedge i_dst_clk) begin
    if (i_dst_rst) begin
      req_s_r    <= 3'h0;
      req_seen_r <= 1'b0;
      o_dst_data <= RST;
      o_dst_tick <= 1'b0;
    end else begin
      req_s_r    <= {req_s_r[1:0], req_r};
      o_dst_tick <= 1'b0;
      if (req_s_r[1] == req_s_r[2] && req_s_r[2] != req_seen_r) begin
        req_seen_r <= req_s_r[2];
        o_dst_data <= hold_r;
        o_dst_tick <= 1'b1;
      end
    end
  end
endmodule

// ==== sbst_tap.sv ====
// boundary scan test port of the synchronous sram, top level
// assumes the test clock is free of the system clock; pins are sampled on the system clock
`timescale 1ns/1ps
`include "sbst_defines.svh"
module sbst_tap #(
  parameter logic [2:0]  P_ID_REV  = 3'h1,     // arbitrary value
  parameter logic [16:0] P_ID_PART = 17'h0a5a5, // arbitrary value
  parameter logic [10:0] P_ID_MFR  = 11'h2b3    // arbitrary value
) (
  // system clock and reset
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_srst,
  // serial test port
  input  wire logic                      i_tck,
  input  wire logic                      i_tms,
  input  wire logic                      i_tdi,
  output logic                           o_tdo,
  output logic                           o_tdo_oe_n,
  // memory core side
  input  wire logic [`SBST_PIN_CNT-1:0]  i_pin_state,
  input  wire logic                      i_q_drive_en,
  output logic                           o_q_oe_n,
  output logic                           o_ring_force,
  output logic      [`SBST_PIN_CNT-1:0]  o_ring_drive
);
  import sbst_pkg::*;

  localparam logic [`SBST_ID_W-1:0] ID_VAL = {P_ID_REV, P_ID_PART, P_ID_MFR,
                                              `SBST_ID_PRES_VAL};
  localparam sbst_ctrl_t CTRL_RST = '{instr: SBST_IDCODE, upd: '0};

  sbst_state_t               state_r;
  sbst_state_t               state_nxt;
  sbst_instr_t               ir_r;
  logic [`SBST_IR_W-1:0]     ir_sh_r;
  logic [`SBST_BSR_LEN-1:0]  bsr_sh_r;
  logic [`SBST_BSR_LEN-1:0]  bsr_upd_r;
  logic [`SBST_ID_W-1:0]     id_sh_r;
  logic                      byp_r;
  logic [2:0]                rst_s_r;
  logic                      tck_rst_r;
  logic [`SBST_PIN_CNT-1:0]  pin_tck;
  sbst_ctrl_t                ctrl_tck;
  sbst_ctrl_t                ctrl_sys;
  logic                      sel_bsr;
  logic                      sel_id;
  logic                      dr_bit;

  // reset for the test clock domain; the port also resets itself by holding mode select high
  always_ff @(posedge i_tck) begin
    rst_s_r <= {rst_s_r[1:0], i_srst};
    if (rst_s_r[1] == rst_s_r[2]) begin
      tck_rst_r <= rst_s_r[2];
    end
  end

  // pin snapshot into the test clock domain; capture takes the latest complete word
  sbst_xfer #(.W(`SBST_PIN_CNT), .RST('0)) u_pin_xfer (
    .i_src_clk  (i_sys_clk),
    .i_src_rst  (i_srst),
    .i_src_data (i_pin_state),
    .i_dst_clk  (i_tck),
    .i_dst_rst  (tck_rst_r),
    .o_dst_data (pin_tck),
    .o_dst_tick ()
  );

  // controller next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SBST_TLR:      state_nxt = i_tms ? SBST_TLR : SBST_RTI;
      SBST_RTI:      state_nxt = i_tms ? SBST_SEL_DR : SBST_RTI;
      SBST_SEL_DR:   state_nxt = i_tms ? SBST_SEL_IR : SBST_CAP_DR;
      SBST_CAP_DR:   state_nxt = i_tms ? SBST_EX1_DR : SBST_SHIFT_DR;
      SBST_SHIFT_DR: state_nxt = i_tms ? SBST_EX1_DR : SBST_SHIFT_DR;
      SBST_EX1_DR:   state_nxt = i_tms ? SBST_UPD_DR : SBST_PAUSE_DR;
      SBST_PAUSE_DR: state_nxt = i_tms ? SBST_EX2_DR : SBST_PAUSE_DR;
      SBST_EX2_DR:   state_nxt = i_tms ? SBST_UPD_DR : SBST_SHIFT_DR;
      SBST_UPD_DR:   state_nxt = i_tms ? SBST_SEL_DR : SBST_RTI;
      SBST_SEL_IR:   state_nxt = i_tms ? SBST_TLR : SBST_CAP_IR;
      SBST_CAP_IR:   state_nxt = i_tms ? SBST_EX1_IR : SBST_SHIFT_IR;
      SBST_SHIFT_IR: state_nxt = i_tms ? SBST_EX1_IR : SBST_SHIFT_IR;
      SBST_EX1_IR:   state_nxt = i_tms ? SBST_UPD_IR : SBST_PAUSE_IR;
      SBST_PAUSE_IR: state_nxt = i_tms ? SBST_EX2_IR : SBST_PAUSE_IR;
      SBST_EX2_IR:   state_nxt = i_tms ? SBST_UPD_IR : SBST_SHIFT_IR;
      SBST_UPD_IR:   state_nxt = i_tms ? SBST_SEL_DR : SBST_RTI;
    endcase
  end

  always_ff @(posedge i_tck) begin
    if (tck_rst_r) begin
      state_r <= SBST_TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // instruction path
  always_ff @(posedge i_tck) begin
    if (tck_rst_r) begin
      ir_sh_r <= `SBST_IR_CAP_VAL;
    end else if (state_r == SBST_CAP_IR) begin
      ir_sh_r <= `SBST_IR_CAP_VAL;
    end else if (state_r == SBST_SHIFT_IR) begin
      ir_sh_r <= {i_tdi, ir_sh_r[`SBST_IR_W-1:1]};
    end
  end

  always_ff @(posedge i_tck) begin
    if (tck_rst_r || state_r == SBST_TLR) begin
      ir_r <= sbst_instr_t'(`SBST_IR_RST_VAL);
    end else if (state_r == SBST_UPD_IR) begin
      ir_r <= sbst_instr_t'(ir_sh_r);
    end
  end

  // data path select; unused codes fall back to bypass so the chain stays intact
  always_comb begin
    sel_bsr = (ir_r == SBST_EXTEST) || (ir_r == SBST_SAMPLEZ)
              || (ir_r == SBST_SAMPLE);
    sel_id  = (ir_r == SBST_IDCODE);
  end

  // boundary chain: msb nearest serial in, lsb drives serial out
  always_ff @(posedge i_tck) begin
    if (tck_rst_r) begin
      bsr_sh_r <= '0;
    end else if (sel_bsr && state_r == SBST_CAP_DR) begin
      bsr_sh_r <= {bsr_upd_r[`SBST_OE_CELL], pin_tck};
    end else if (sel_bsr && state_r == SBST_SHIFT_DR) begin
      bsr_sh_r <= {i_tdi, bsr_sh_r[`SBST_BSR_LEN-1:1]};
    end
  end

  // update latches; the output enable cell must come up low
  always_ff @(posedge i_tck) begin
    if (tck_rst_r || state_r == SBST_TLR) begin
      bsr_upd_r                <= '0;
      bsr_upd_r[`SBST_OE_CELL] <= `SBST_OE_CELL_RST;
    end else if (sel_bsr && state_r == SBST_UPD_DR) begin
      bsr_upd_r <= bsr_sh_r;
    end
  end

  // identification register
  always_ff @(posedge i_tck) begin
    if (tck_rst_r) begin
      id_sh_r <= '0;
    end else if (sel_id && state_r == SBST_CAP_DR) begin
      id_sh_r <= ID_VAL;
    end else if (sel_id && state_r == SBST_SHIFT_DR) begin
      id_sh_r <= {i_tdi, id_sh_r[`SBST_ID_W-1:1]};
    end
  end

  // bypass cell captures zero
  always_ff @(posedge i_tck) begin
    if (tck_rst_r) begin
      byp_r <= 1'b0;
    end else if (!sel_bsr && !sel_id && state_r == SBST_CAP_DR) begin
      byp_r <= 1'b0;
    end else if (!sel_bsr && !sel_id && state_r == SBST_SHIFT_DR) begin
      byp_r <= i_tdi;
    end
  end

  always_comb begin
    if (sel_bsr) begin
      dr_bit = bsr_sh_r[0];
    end else if (sel_id) begin
      dr_bit = id_sh_r[0];
    end else begin
      dr_bit = byp_r;
    end
  end

  // launch on the falling edge gives the controller half a period of margin
  always_ff @(negedge i_tck) begin
    if (tck_rst_r) begin
      o_tdo      <= 1'b0;
      o_tdo_oe_n <= 1'b1;
    end else if (state_r == SBST_SHIFT_IR) begin
      o_tdo      <= ir_sh_r[0];
      o_tdo_oe_n <= 1'b0;
    end else if (state_r == SBST_SHIFT_DR) begin
      o_tdo      <= dr_bit;
      o_tdo_oe_n <= 1'b0;
    end else begin
      o_tdo_oe_n <= 1'b1;
    end
  end

  // instruction and update latches into the system clock domain
  always_comb begin
    ctrl_tck       = CTRL_RST;
    ctrl_tck.instr = ir_r;
    ctrl_tck.upd   = bsr_upd_r;
  end

  sbst_xfer #(.W($bits(sbst_ctrl_t)), .RST(CTRL_RST)) u_ctrl_xfer (
    .i_src_clk  (i_tck),
    .i_src_rst  (tck_rst_r),
    .i_src_data (ctrl_tck),
    .i_dst_clk  (i_sys_clk),
    .i_dst_rst  (i_srst),
    .o_dst_data (ctrl_sys),
    .o_dst_tick ()
  );

  // memory output drivers; normal operation only when no test instruction claims them
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_q_oe_n     <= 1'b1;
      o_ring_force <= 1'b0;
      o_ring_drive <= '0;
    end else begin
      o_ring_drive <= ctrl_sys.upd[`SBST_PIN_CNT-1:0];
      if (ctrl_sys.instr == SBST_EXTEST) begin
        o_ring_force <= 1'b1;
        o_q_oe_n     <= ~ctrl_sys.upd[`SBST_OE_CELL];
      end else if (ctrl_sys.instr == SBST_SAMPLEZ) begin
        o_ring_force <= 1'b0;
        o_q_oe_n     <= 1'b1;
      end else begin
        o_ring_force <= 1'b0;
        o_q_oe_n     <= ~i_q_drive_en;
      end
    end
  end

  // checks in the test clock domain
  sequence s_tms_high_run;
    i_tms [*5];
  endsequence

  sequence s_id_capture;
    state_r == SBST_CAP_DR && ir_r == SBST_IDCODE;
  endsequence

  sequence s_bsr_capture;
    state_r == SBST_CAP_DR && sel_bsr;
  endsequence

  chk_tms_reset_run: assert property (@(posedge i_tck) disable iff (tck_rst_r)
    s_tms_high_run |=> state_r == SBST_TLR)
    else $error("five high mode selects did not reach reset");

  chk_tms_leave_reset: assert property (@(posedge i_tck) disable iff (tck_rst_r)
    (state_r == SBST_TLR && !i_tms) |=> state_r == SBST_RTI)
    else $error("low mode select did not leave reset");

  chk_ir_reset_id: assert property (@(posedge i_tck) disable iff (tck_rst_r)
    state_r == SBST_TLR |=> ir_r == SBST_IDCODE)
    else $error("instruction not idcode after reset state");

  chk_ir_update_val: assert property (@(posedge i_tck) disable iff (tck_rst_r)
    state_r == SBST_UPD_IR |=> ir_r == $past(ir_sh_r))
    else $error("instruction not taken at update");

  chk_id_capture_val: assert property (@(posedge i_tck) disable iff (tck_rst_r)
    s_id_capture |=> id_sh_r == ID_VAL ##1 id_sh_r[`SBST_ID_W-1] == $past(i_tdi)
      || state_r != SBST_SHIFT_DR)
    else $error("identification value wrong at capture");

  chk_id_presence_bit: assert property (@(posedge i_tck) disable iff (tck_rst_r)
    s_id_capture |=> id_sh_r[`SBST_ID_PRES_BIT] == 1'b1)
    else $error("identification presence bit not one");

  chk_bsr_capture_pins: assert property (@(posedge i_tck) disable iff (tck_rst_r)
    s_bsr_capture |=> bsr_sh_r[`SBST_PIN_CNT-1:0] == $past(pin_tck)
      && bsr_sh_r[`SBST_OE_CELL] == $past(bsr_upd_r[`SBST_OE_CELL]))
    else $error("boundary capture missed pin state");

  chk_bsr_shift_dir: assert property (@(posedge i_tck) disable iff (tck_rst_r)
    (state_r == SBST_SHIFT_DR && sel_bsr) |=>
      bsr_sh_r == {$past(i_tdi), $past(bsr_sh_r[`SBST_BSR_LEN-1:1])})
    else $error("boundary chain shifted the wrong way");

  chk_bypass_path: assert property (@(posedge i_tck) disable iff (tck_rst_r)
    (state_r == SBST_SHIFT_DR && ir_r == SBST_BYPASS && $stable(state_r)) |->
      o_tdo == byp_r && !o_tdo_oe_n)
    else $error("bypass cell not on serial out");

  chk_tdo_idle_off: assert property (@(posedge i_tck) disable iff (tck_rst_r)
    (state_r == SBST_RTI && $past(state_r) == SBST_RTI) |-> o_tdo_oe_n)
    else $error("serial out driven outside shift");

  // checks in the system clock domain
  chk_samplez_hiz: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    ctrl_sys.instr == SBST_SAMPLEZ |=> o_q_oe_n && !o_ring_force)
    else $error("drivers enabled under samplez");

  chk_extest_oe_cell: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    ctrl_sys.instr == SBST_EXTEST |=>
      o_q_oe_n == !$past(ctrl_sys.upd[`SBST_OE_CELL]) && o_ring_force)
    else $error("extest drivers not following cell 108");

  chk_sample_normal: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    ctrl_sys.instr == SBST_SAMPLE |=> o_q_oe_n == !$past(i_q_drive_en))
    else $error("sample disturbed normal drivers");
endmodule

// ==== sbst_ctl_model.sv ====
// test controller model: drives the serial test port, reads serial data out
// assumes the design launches serial data out on the falling test clock
`timescale 1ns/1ps
module sbst_ctl_model (
  // serial test port
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe_n
);
  int unsigned bad_cnt;

  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    bad_cnt = 0;
  end

  // clock stands low between calls; tms and tdi move only while it is low
  task automatic cyc(input logic tms_v, input logic tdi_v, input logic shf, output logic tdo_v);
    #0.5;
    o_tms = tms_v;
    o_tdi = tdi_v;
    #7.0 o_tck = 1'b1;
    tdo_v = i_tdo;
    if (shf && i_tdo_oe_n !== 1'b0) bad_cnt++;
    #7.4;
    // serial out must not move on the rising edge
    if (i_tdo !== tdo_v) bad_cnt++;
    #0.1 o_tck = 1'b0;
  endtask

  // idle data toggles so a stale level never passes for shifted data
  task automatic idle(input int n);
    logic d;
    repeat (n) cyc(1'b0, ~o_tdi, 1'b0, d);
  endtask

  task automatic tlr();
    logic d;
    repeat (5) cyc(1'b1, ~o_tdi, 1'b0, d);
    idle(1);
  endtask

  // callers pass only the five defined codes
  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    logic d;
    cyc(1'b1, ~o_tdi, 1'b0, d);
    cyc(1'b1, ~o_tdi, 1'b0, d);
    cyc(1'b0, ~o_tdi, 1'b0, d);
    cyc(1'b0, ~o_tdi, 1'b0, d);
    for (int i = 0; i < 3; i++) cyc(i == 2, code[i], 1'b1, cap[i]);
    cyc(1'b1, ~o_tdi, 1'b0, d);
    idle(20);
  endtask

  task automatic shift_dr(input int n, input logic [108:0] din, output logic [108:0] dout);
    logic d;
    dout = '0;
    cyc(1'b1, ~o_tdi, 1'b0, d);
    cyc(1'b0, ~o_tdi, 1'b0, d);
    cyc(1'b0, ~o_tdi, 1'b0, d);
    for (int i = 0; i < n; i++) cyc(i == n - 1, din[i], 1'b1, dout[i]);
    cyc(1'b1, ~o_tdi, 1'b0, d);
    idle(20);
  endtask
endmodule

// ==== test_sram_boundary_scan_tap.sv ====
// self-checking bench of the boundary scan test port
// assumes the controller model drives the test clock only inside its tasks
`timescale 1ns/1ps
`include "sbst_defines.svh"
module test_sram_boundary_scan_tap;
  import sbst_pkg::*;
  localparam int          L      = `SBST_BSR_LEN;
  localparam logic [2:0]  T_REV  = 3'h6;      // arbitrary value
  localparam logic [16:0] T_PART = 17'h1c3e7; // arbitrary value
  localparam logic [10:0] T_MFR  = 11'h15a;   // arbitrary value

  logic         i_sys_clk;
  logic         i_srst;
  logic         i_q_drive_en;
  logic [107:0] i_pin_state;
  logic [107:0] pins;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic         o_tdo;
  logic         o_tdo_oe_n;
  logic         o_q_oe_n;
  logic         o_ring_force;
  logic [107:0] o_ring_drive;
  int           error_cnt;
  int           checks;
  integer       seed = 32'h2f2760cf;

  sbst_tap #(.P_ID_REV(T_REV), .P_ID_PART(T_PART), .P_ID_MFR(T_MFR)) dut (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .i_pin_state(i_pin_state),
    .i_q_drive_en(i_q_drive_en), .o_q_oe_n(o_q_oe_n), .o_ring_force(o_ring_force),
    .o_ring_drive(o_ring_drive)
  );

  sbst_ctl_model ctl (
    .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(o_tdo), .i_tdo_oe_n(o_tdo_oe_n)
  );

  initial i_sys_clk = 1'b0;
  always #20 i_sys_clk = ~i_sys_clk;

  function automatic logic [L-1:0] rnd();
    return L'({$random(seed), $random(seed), $random(seed), $random(seed)});
  endfunction

  function automatic logic [L-1:0] exp_id();
    return L'({T_REV, T_PART, T_MFR, `SBST_ID_PRES_VAL});
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [L-1:0] exp, input logic [L-1:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic sys_drive(input logic qen);
    logic [L-1:0] v;
    v = rnd();
    @(posedge i_sys_clk);
    i_q_drive_en <= qen;
    i_pin_state <= v[107:0];
    pins = v[107:0];
  endtask

  // the crossing needs the test clock, so it runs while we wait
  task automatic wait_out(input logic fe, input logic oe, input logic [107:0] dv,
                          input logic use_dv);
    int n;
    n = 0;
    checks++;
    while (n < 60 && (o_ring_force !== fe || o_q_oe_n !== oe ||
                      (use_dv && o_ring_drive !== dv))) begin
      ctl.idle(1);
      @(negedge i_sys_clk);
      n++;
    end
    if (n == 60) begin
      error_cnt++;
      $display("ERROR sys_outputs expected %b %b %h seen %b %b %h", fe, oe, dv,
               o_ring_force, o_q_oe_n, o_ring_drive);
      complete_run();
    end
  endtask

  initial begin
    #300000;
    error_cnt++;
    $display("ERROR run_time expected finish seen timeout");
    complete_run();
  end

  initial begin
    logic [L-1:0] din;
    logic [L-1:0] dout;
    logic [2:0]   cap;
    error_cnt = 0;
    checks = 0;
    i_srst = 1'b1;
    i_q_drive_en = 1'b0;
    i_pin_state = '0;
    // test side resets through a synchroniser, so its clock must run meanwhile
    fork
      repeat (2) @(posedge i_sys_clk);
      ctl.idle(6);
    join
    @(posedge i_sys_clk);
    i_srst <= 1'b0;
    ctl.idle(6);

    sys_drive(1'b1);
    wait_out(1'b0, 1'b0, '0, 1'b0);
    ctl.shift_dr(32, rnd(), dout);
    chk("idcode", exp_id(), L'(dout[31:0]));
    $display("test idcode done");

    ctl.load_ir(SBST_BYPASS, cap);
    chk("ir_capture", L'(`SBST_IR_CAP_VAL), L'(cap));
    din = rnd();
    ctl.shift_dr(8, din, dout);
    chk("bypass", L'({din[6:0], 1'b0}), L'(dout[7:0]));
    // normal drivers must follow the core's enable both ways
    sys_drive(1'b0);
    wait_out(1'b0, 1'b1, '0, 1'b1);
    $display("test bypass done");

    sys_drive(1'b1);
    ctl.load_ir(SBST_SAMPLE, cap);
    din = rnd();
    din[108] = 1'b1;
    ctl.shift_dr(L, din, dout);
    chk("sample_ring", {1'b0, pins}, dout);
    wait_out(1'b0, 1'b0, din[107:0], 1'b1);
    $display("test sample done");

    ctl.load_ir(SBST_EXTEST, cap);
    wait_out(1'b1, 1'b0, din[107:0], 1'b1);
    sys_drive(1'b0);
    // fresh pins need a full handshake round trip before capture
    ctl.idle(40);
    din = rnd();
    din[108] = 1'b0;
    ctl.shift_dr(L, din, dout);
    chk("extest_ring", {1'b1, pins}, dout);
    wait_out(1'b1, 1'b1, din[107:0], 1'b1);
    $display("test extest done");

    sys_drive(1'b1);
    ctl.load_ir(SBST_SAMPLEZ, cap);
    wait_out(1'b0, 1'b1, din[107:0], 1'b1);
    din = rnd();
    din[108] = 1'b1;
    ctl.shift_dr(L, din, dout);
    chk("samplez_ring", {1'b0, pins}, dout);
    $display("test samplez done");

    ctl.tlr();
    wait_out(1'b0, 1'b0, '0, 1'b0);
    ctl.shift_dr(32, rnd(), dout);
    chk("idcode_tlr", exp_id(), L'(dout[31:0]));
    ctl.load_ir(SBST_SAMPLE, cap);
    ctl.shift_dr(L, rnd(), dout);
    chk("cell108_tlr", L'(1'b0), L'(dout[108]));
    chk("tdo_timing", '0, L'(ctl.bad_cnt));
    $display("test tms reset done");
    complete_run();
  end
endmodule
